/* src/fns_consts.vh */
// constants for the fractional-n synthesizer control block
// What this block does
// - 9-bit integer divider plus 18-bit sigma-delta modulator with 8-level quantizer.
// - modulator dithers division ratio; average equals programmed fraction, noise whitened.
// - tuning voltage sorted into four ranges; range charge pump level applied per channel.
// - integer divider word stays within 6 to 511 decimal.
// - reference output divide 0 gives 40 MHz clock, 1 gives 20 MHz.
// - crystal clock drives synthesizer reference and all other on-chip logic.
// - six oscillators with two bands each give 12 choices, picked automatically.
// - host may force oscillator and band, overriding automatic choice.
`ifndef FNS_CONSTS_VH
`define FNS_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FNS_REG_REFDIV    8'h02
`define FNS_REG_CPLEVEL   8'h11
`define FNS_REG_MODCTL    8'h10
`define FNS_REG_INT_HI    8'h19
`define FNS_REG_INT_LO    8'h1a
`define FNS_REG_FRAC_MID  8'h1b
`define FNS_REG_FRAC_LO   8'h1c
`define FNS_REG_LODIV     8'h18
`define FNS_REG_VCOCTL    8'h1e
`define FNS_REG_STATUS    8'h1d

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FNS_BIT_REF_SEL   1
`define FNS_BIT_REF_ODIV  2
`define FNS_BIT_MOD_BYP   6
`define FNS_BIT_LO_SEL    6
`define FNS_BIT_TUNE_GO   4
`define FNS_BIT_FORCE     7

// ----------------------------------------------------------------
// widths, limits, reset values
// ----------------------------------------------------------------
`define FNS_INT_W         9
`define FNS_FRAC_W        18
`define FNS_INT_MIN       9'h006
`define FNS_INT_OFFSET    10'h020
`define FNS_VCO_COUNT     4'hc
`define FNS_REG_RST       8'h00
`define FNS_CP_RST        8'hf8

`endif

/* src/fns_mash.v */
// sigma-delta modulator: three-stage error feedback, outputs offset in -3..+4
`timescale 1ns/1ps
`default_nettype none
`include "fns_consts.vh"

module fns_mash (
    input  wire                   clk,      // reference clock
    input  wire                   rst_n,    // synced reset, active low
    input  wire                   step,     // one reference cycle enable
    input  wire                   bypass,   // integer mode
    input  wire [`FNS_FRAC_W-1:0] frac,     // fraction word
    output reg  [3:0]             offset_r  // signed division offset
);
    reg  [`FNS_FRAC_W-1:0] acc1_r;
    reg  [`FNS_FRAC_W-1:0] acc2_r;
    reg  [`FNS_FRAC_W-1:0] acc3_r;
    reg                    c2_d_r;
    reg  [1:0]             c3_d_r;
    wire [`FNS_FRAC_W:0]   s1 = {1'b0, acc1_r} + {1'b0, frac};
    wire [`FNS_FRAC_W:0]   s2 = {1'b0, acc2_r} + {1'b0, s1[`FNS_FRAC_W-1:0]};
    wire [`FNS_FRAC_W:0]   s3 = {1'b0, acc3_r} + {1'b0, s2[`FNS_FRAC_W-1:0]};
    // mash 1-1-1: c1 + (c2 - c2') + (c3 - 2c3' + c3''), range -3..+4 (8 levels)
    wire signed [3:0] comb = $signed({3'b000, s1[`FNS_FRAC_W]})
                           + $signed({3'b000, s2[`FNS_FRAC_W]})
                           - $signed({3'b000, c2_d_r})
                           + $signed({3'b000, s3[`FNS_FRAC_W]})
                           - $signed({2'b00, c3_d_r[0], 1'b0})
                           + $signed({3'b000, c3_d_r[1]});

    // accumulators cleared in integer mode so no residue dithers on release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc1_r   <= {`FNS_FRAC_W{1'b0}};
            acc2_r   <= {`FNS_FRAC_W{1'b0}};
            acc3_r   <= {`FNS_FRAC_W{1'b0}};
            c2_d_r   <= 1'b0;
            c3_d_r   <= 2'b00;
            offset_r <= 4'h0;
        end else if (bypass) begin
            acc1_r   <= {`FNS_FRAC_W{1'b0}};
            acc2_r   <= {`FNS_FRAC_W{1'b0}};
            acc3_r   <= {`FNS_FRAC_W{1'b0}};
            c2_d_r   <= 1'b0;
            c3_d_r   <= 2'b00;
            offset_r <= 4'h0;
        end else if (step) begin
            acc1_r   <= s1[`FNS_FRAC_W-1:0];
            acc2_r   <= s2[`FNS_FRAC_W-1:0];
            acc3_r   <= s3[`FNS_FRAC_W-1:0];
            c2_d_r   <= s2[`FNS_FRAC_W];
            c3_d_r   <= {c3_d_r[0], s3[`FNS_FRAC_W]};
            offset_r <= comb;
        end
    end
endmodule // fns_mash
`default_nettype wire

/* src/fns_synth_ctrl.v */
// top of the fractional-n synthesizer control: registers, divider, cp and vco select
`timescale 1ns/1ps
`default_nettype none
`include "fns_consts.vh"

module fns_synth_ctrl (
    input  wire       clk,            // crystal-derived clock
    input  wire       rstn,           // async reset, active low
    input  wire       reg_wr,         // register write strobe from serial port
    input  wire [7:0] reg_addr,       // register address
    input  wire [7:0] reg_wdata,      // write data
    output reg  [7:0] reg_rdata,      // read data, registered
    input  wire [1:0] tune_range,     // tuning voltage range from comparator
    input  wire [3:0] auto_vco,       // automatic oscillator/band choice
    input  wire       fb_edge,        // prescaler cycle end, one pulse
    output reg  [9:0] div_ratio_r,    // instantaneous feedback division
    output reg  [1:0] cp_level_r,     // charge pump current level
    output reg  [3:0] vco_sel_r,      // oscillator index [3:1], band [0]
    output reg        ref_div_r,      // reference divider select
    output reg        lo_div_r,       // lo divider select
    output reg        tune_start_r,   // one-pulse channel change start
    output reg        reference_clock_output // reference clock out
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reg rst_s1_r;
    reg rst_n_r;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg [7:0] reference_divider_control_r;
    reg [7:0] modulator_control_r;
    reg [7:0] lo_divider_control_r;
    reg [7:0] cp_levels_r;
    reg [7:0] vco_ctl_r;
    reg [7:0] int_hi_r;
    reg [7:0] int_lo_r;
    reg [7:0] frac_mid_r;
    reg [7:0] frac_lo_r;
    reg       go_nxt;

    // held until rewritten; only the start bit acts as a pulse
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reference_divider_control_r <= `FNS_REG_RST;
            modulator_control_r         <= `FNS_REG_RST;
            lo_divider_control_r        <= `FNS_REG_RST;
            cp_levels_r                 <= `FNS_CP_RST;
            vco_ctl_r                   <= `FNS_REG_RST;
            int_hi_r                    <= `FNS_REG_RST;
            int_lo_r                    <= `FNS_REG_RST;
            frac_mid_r                  <= `FNS_REG_RST;
            frac_lo_r                   <= `FNS_REG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `FNS_REG_REFDIV)
                reference_divider_control_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_MODCTL)
                modulator_control_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_LODIV)
                lo_divider_control_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_CPLEVEL)
                cp_levels_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_VCOCTL)
                vco_ctl_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_INT_HI)
                int_hi_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_INT_LO)
                int_lo_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_FRAC_MID)
                frac_mid_r <= reg_wdata;
            else if (reg_addr == `FNS_REG_FRAC_LO)
                frac_lo_r <= reg_wdata;
        end
    end

    // start pulse for a write to the last divider byte with start set
    always @* begin
        go_nxt = reg_wr && (reg_addr == `FNS_REG_FRAC_LO)
                 && reg_wdata[`FNS_BIT_TUNE_GO];
    end

    // ------------------------------------------------------------
    // divider words
    // ------------------------------------------------------------
    // int: hi[7:0] + lo[7] ; frac: lo[1:0], mid[7:0], frac_lo[7:0]
    wire [`FNS_INT_W-1:0]  int_word  = {int_hi_r, int_lo_r[7]};
    wire [`FNS_FRAC_W-1:0] frac_word = {int_lo_r[1:0], frac_mid_r, frac_lo_r};
    wire                   bypass    = modulator_control_r[`FNS_BIT_MOD_BYP];
    // words below the floor are clamped so the divider never runs short
    wire [`FNS_INT_W-1:0]  int_safe  = (int_word < `FNS_INT_MIN) ?
                                       `FNS_INT_MIN : int_word;

    // ------------------------------------------------------------
    // modulator and feedback ratio
    // ------------------------------------------------------------
    wire [3:0] sd_off;
    fns_mash u_mash (
        .clk      (clk),
        .rst_n    (rst_n_r),
        .step     (fb_edge),
        .bypass   (bypass),
        .frac     (frac_word),
        .offset_r (sd_off)
    );

    // n = int + 32 + dither; 10 bits covers 38..543+4
    wire [9:0] base_n = {1'b0, int_safe} + `FNS_INT_OFFSET;
    wire [9:0] sd_ext = {{6{sd_off[3]}}, sd_off};
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            div_ratio_r <= 10'h000;
        else if (fb_edge)
            div_ratio_r <= bypass ? base_n : base_n + sd_ext;
    end

    // ------------------------------------------------------------
    // charge pump level, latched once per channel change
    // ------------------------------------------------------------
    reg [1:0] cp_pick;
    always @* begin
        case (tune_range)
            2'd0:    cp_pick = cp_levels_r[7:6];
            2'd1:    cp_pick = cp_levels_r[5:4];
            2'd2:    cp_pick = cp_levels_r[3:2];
            default: cp_pick = cp_levels_r[1:0];
        endcase
    end

    // sample one cycle after start so tune_range reflects the new channel
    reg go_d_r;
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tune_start_r <= 1'b0;
            go_d_r       <= 1'b0;
            cp_level_r   <= 2'b00;
        end else begin
            tune_start_r <= go_nxt;
            go_d_r       <= tune_start_r;
            if (go_d_r)
                cp_level_r <= cp_pick;
        end
    end

    // ------------------------------------------------------------
    // oscillator select: forced beats automatic
    // ------------------------------------------------------------
    wire force_en = vco_ctl_r[`FNS_BIT_FORCE];
    wire auto_ok  = (auto_vco < `FNS_VCO_COUNT);
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            vco_sel_r <= 4'h0;
        else if (force_en && vco_ctl_r[3:0] < `FNS_VCO_COUNT)
            vco_sel_r <= vco_ctl_r[3:0];
        else if (!force_en && auto_ok)
            vco_sel_r <= auto_vco;
    end

    // ------------------------------------------------------------
    // divider selects and reference output
    // ------------------------------------------------------------
    // clk stands in for the crystal: half_r is the full-rate tone and quart_r
    // the halved one; a flop cannot repeat clk itself, so only the 2:1 ratio holds
    reg half_r;
    reg quart_r;
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            half_r                 <= 1'b0;
            quart_r                <= 1'b0;
            ref_div_r              <= 1'b0;
            lo_div_r               <= 1'b0;
            reference_clock_output <= 1'b0;
        end else begin
            half_r    <= ~half_r;
            if (half_r)
                quart_r <= ~quart_r;
            ref_div_r <= reference_divider_control_r[`FNS_BIT_REF_SEL];
            lo_div_r  <= lo_divider_control_r[`FNS_BIT_LO_SEL];
            reference_clock_output <=
                reference_divider_control_r[`FNS_BIT_REF_ODIV] ? quart_r : half_r;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r)
            reg_rdata <= 8'h00;
        else if (reg_addr == `FNS_REG_REFDIV)
            reg_rdata <= reference_divider_control_r;
        else if (reg_addr == `FNS_REG_MODCTL)
            reg_rdata <= modulator_control_r;
        else if (reg_addr == `FNS_REG_LODIV)
            reg_rdata <= lo_divider_control_r;
        else if (reg_addr == `FNS_REG_CPLEVEL)
            reg_rdata <= cp_levels_r;
        else if (reg_addr == `FNS_REG_VCOCTL)
            reg_rdata <= vco_ctl_r;
        else if (reg_addr == `FNS_REG_INT_HI)
            reg_rdata <= int_hi_r;
        else if (reg_addr == `FNS_REG_INT_LO)
            reg_rdata <= int_lo_r;
        else if (reg_addr == `FNS_REG_FRAC_MID)
            reg_rdata <= frac_mid_r;
        else if (reg_addr == `FNS_REG_FRAC_LO)
            reg_rdata <= frac_lo_r;
        else if (reg_addr == `FNS_REG_STATUS)
            reg_rdata <= {2'b00, cp_level_r, vco_sel_r};
        else
            reg_rdata <= 8'h00;
    end
endmodule // fns_synth_ctrl
`default_nettype wire

/* tb/fns_props.sv */
// assertion checker watching the synthesizer control ports
`timescale 1ns/1ps
`default_nettype none
module fns_props (
    input wire logic       clk,          // clock
    input wire logic       rstn,         // reset, low
    input wire logic       reg_wr,       // write strobe
    input wire logic [7:0] reg_addr,     // address
    input wire logic [7:0] reg_wdata,    // write data
    input wire logic [7:0] reg_rdata,    // read data
    input wire logic [1:0] tune_range,   // tuning range
    input wire logic [3:0] auto_vco,     // auto choice
    input wire logic       fb_edge,      // divider step
    input wire logic [9:0] div_ratio_r,  // ratio
    input wire logic [1:0] cp_level_r,   // pump level
    input wire logic [3:0] vco_sel_r,    // oscillator
    input wire logic       ref_div_r,    // ref select
    input wire logic       lo_div_r,     // lo select
    input wire logic       tune_start_r, // start pulse
    input wire logic       reference_clock_output // ref clock
);
    logic [2:0] up_r;
    logic [8:0] int_r;
    logic [7:0] cpl_r;
    logic [3:0] fix_r;
    logic       byp_r;
    logic       frc_r;
    logic       odv_r;
    wire        live  = up_r == 3'h4;
    wire        wr    = live && reg_wr;
    wire  [9:0] exp_w = (int_r < 9'h006) ? 10'h026 : {1'b0, int_r} + 10'h020;
    wire  [1:0] cp_w  = cpl_r[3'h7 - {tune_range, 1'b0} -: 2];
    // shadow of written settings; waits out the reset sync inside
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_r  <= 3'h0;
            int_r <= 9'h000;
            cpl_r <= 8'hf8;
            fix_r <= 4'h0;
            byp_r <= 1'b0;
            frc_r <= 1'b0;
            odv_r <= 1'b0;
        end else begin
            if (!live) up_r <= up_r + 3'h1;
            if (wr && reg_addr == 8'h19) int_r[8:1] <= reg_wdata;
            if (wr && reg_addr == 8'h1a) int_r[0] <= reg_wdata[7];
            if (wr && reg_addr == 8'h11) cpl_r <= reg_wdata;
            if (wr && reg_addr == 8'h10) byp_r <= reg_wdata[6];
            if (wr && reg_addr == 8'h1e) frc_r <= reg_wdata[7];
            if (wr && reg_addr == 8'h1e) fix_r <= reg_wdata[3:0];
            if (wr && reg_addr == 8'h02) odv_r <= reg_wdata[2];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_hold; !fb_edge |=> $stable(div_ratio_r); endproperty
    a_hold: assert property (p_hold) else $error("ratio moved without step");
    property p_byp; live && fb_edge && byp_r |=> div_ratio_r == $past(exp_w); endproperty
    a_byp: assert property (p_byp) else $error("integer mode ratio off");
    property p_frac; live && fb_edge && !byp_r |=> div_ratio_r + 10'h003 >= $past(exp_w)
        && div_ratio_r <= $past(exp_w) + 10'h004; endproperty
    a_frac: assert property (p_frac) else $error("ratio outside modulator span");
    property p_sel; wr && reg_addr == 8'h02 |=> ##1 ref_div_r == $past(reg_wdata[1], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("ref select not taken");
    property p_keep; live && !(reg_wr && reg_addr == 8'h18) |=> ##1 $stable(lo_div_r);
    endproperty
    a_keep: assert property (p_keep) else $error("lo select changed alone");
    property p_go; wr && reg_addr == 8'h1c && reg_wdata[4] |=> tune_start_r ##1 !tune_start_r;
    endproperty
    a_go: assert property (p_go) else $error("start pulse wrong");
    property p_cp; tune_start_r |-> ##2 cp_level_r == $past(cp_w); endproperty
    a_cp: assert property (p_cp) else $error("pump level wrong");
    property p_force; live && frc_r && fix_r < 4'hc |=> vco_sel_r == $past(fix_r); endproperty
    a_force: assert property (p_force) else $error("forced vco lost");
    property p_auto; live && !frc_r && auto_vco < 4'hc |=> vco_sel_r == $past(auto_vco);
    endproperty
    a_auto: assert property (p_auto) else $error("auto vco lost");
    property p_clk; live && !odv_r && !$past(odv_r) |=>
        reference_clock_output != $past(reference_clock_output); endproperty
    a_clk: assert property (p_clk) else $error("ref clock stuck");
    property p_half; live && odv_r && $past(odv_r) && $past(odv_r, 2)
        && $changed(reference_clock_output) |=> $stable(reference_clock_output); endproperty
    a_half: assert property (p_half) else $error("divided ref clock too fast");
endmodule // fns_props
bind fns_synth_ctrl fns_props fns_props_i (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .tune_range, .auto_vco, .fb_edge, .div_ratio_r, .cp_level_r, .vco_sel_r, .ref_div_r,
    .lo_div_r, .tune_start_r, .reference_clock_output);
`default_nettype wire

/* tb/fns_host.sv */
// host controller model: works out divider words and writes them
`timescale 1ns/1ps
`default_nettype none
module fns_host (
    input  wire logic       clk,       // clock
    input  wire logic [7:0] reg_rdata, // read data
    output var  logic       reg_wr,    // write strobe
    output var  logic [7:0] reg_addr,  // address
    output var  logic [7:0] reg_wdata  // write data
);
    int   int_w;
    int   frac_w;
    logic byp_w;
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // strobe held across back-to-back bytes; idle drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic idle;
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask
    // fv in kHz on a 40 MHz crystal; fraction kept below one half
    task automatic tune(input real fv, input logic rs, input logic ls);
        real n, st, d;
        st = rs ? 40000.0 : 80000.0;
        n = fv / st;
        int_w = $rtoi(n + 0.5) - 32;
        d = (n - int_w - 32) * st;
        if (d > st / 2 - 125 && d < st / 2 + 125) d = st / 2 - 125;
        byp_w = d < 250.0 && d > -250.0;
        frac_w = $rtoi(d / st * 262144.0 + 0.5) | 16;
        wr(8'h18, {1'b0, ls, 6'h00});
        wr(8'h02, {6'h00, rs, 1'b0});
        wr(8'h10, {1'b0, byp_w, 6'h00});
        wr(8'h19, int_w[8:1]);
        wr(8'h1a, {int_w[0], 5'h00, frac_w[17:16]});
        wr(8'h1b, frac_w[15:8]);
        wr(8'h1c, frac_w[7:0]); // start bit doubles as fraction bit 4
        idle;
    endtask
endmodule // fns_host
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin error_cnt++; \
    $display("BAD %s exp %0d got %0d", nm, e, g); end end
module tb;
    logic        clk, rstn, reg_wr, fb_edge, ref_div_r, lo_div_r, tune_start_r, refclk, rc, rs;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
    logic [1:0]  tune_range, cp_level_r;
    logic [3:0]  auto_vco, vco_sel_r;
    logic [9:0]  div_ratio_r;
    logic [31:0] seed = 32'h6400;
    int          error_cnt, samples_checked, cyc, w;
    real         f;
    fns_synth_ctrl fns_synth_ctrl_i (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .tune_range, .auto_vco, .fb_edge, .div_ratio_r, .cp_level_r, .vco_sel_r, .ref_div_r,
        .lo_div_r, .tune_start_r, .reference_clock_output(refclk));
    fns_host fns_host_i (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        fns_host_i.rd(a, rd);
        `CHK("rdata", e, rd)
    endtask
    // one step every two cycles; the offsets feed the mean check
    task automatic steps(input int n);
        int q[$];
        int e;
        longint d;
        e = fns_host_i.int_w + 32;
        repeat (n) begin
            fb_edge <= 1'b1;
            @(posedge clk);
            fb_edge <= 1'b0;
            @(negedge clk);
            q.push_back(int'(div_ratio_r) - e);
            @(posedge clk);
            if (fns_host_i.byp_w) `CHK("ratio", e, div_ratio_r)
            else `CHK("offset", 1'b1, q[$] >= -3 && q[$] <= 4)
        end
        d = longint'(q.sum()) * 262144 - longint'(fns_host_i.frac_w) * n;
        if (!fns_host_i.byp_w) `CHK("mean", 1'b1, d <= 1048576 && d >= -1048576)
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard: the plan needs about 25k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            stop_test;
        end
    end
    initial begin
        rstn = 1'b0;
        fb_edge = 1'b0;
        tune_range = 2'h0;
        auto_vco = 4'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(8'h11, 8'hf8);
        rdchk(8'h10, 8'h00);
        rdchk(8'h55, 8'h00);
        fns_host_i.wr(8'h02, 8'h06);
        fns_host_i.idle;
        rdchk(8'h02, 8'h06);
        `CHK("refsel", 1'b1, ref_div_r)
        // edges in four cycles: two when divided, four at full rate
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            rc = refclk;
            w = 0;
            repeat (4) begin
                @(negedge clk);
                w += int'(refclk != rc);
                rc = refclk;
            end
            `CHK("refclk", k ? 4 : 2, w)
            @(posedge clk);
            fns_host_i.wr(8'h02, 8'h02);
            fns_host_i.idle;
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        $display("test registers done");
        // random channels, the word limits, then a fraction near one half
        for (int i = 0; i < 6; i++) begin
            w = i == 3 ? 6 : i == 4 ? 511 : 6 + rnd() % 400;
            rs = 1'(rnd() % 2);
            f = i == 5 ? 0.499 : 0.05 + (rnd() % 400) / 1000.0;
            fns_host_i.tune((w + 32 + f) * (rs ? 40000.0 : 80000.0), rs, ~rs);
            steps(2048);
            `CHK("losel", ~rs, lo_div_r)
        end
        fns_host_i.tune(132.0 * 80000.0 + 100.0, 1'b0, 1'b0);
        steps(64);
        // integer word 2 is below the floor and must run as 6 + 32
        fns_host_i.wr(8'h19, 8'h01);
        fns_host_i.idle;
        fb_edge <= 1'b1;
        @(posedge clk);
        fb_edge <= 1'b0;
        @(negedge clk);
        `CHK("floor", 38, div_ratio_r)
        @(posedge clk);
        $display("test divider done");
        fns_host_i.wr(8'h11, 8'h1b);
        for (int r = 0; r < 4; r++) begin
            tune_range <= 2'(r);
            fns_host_i.wr(8'h1c, 8'h10);
            fns_host_i.idle;
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK("cplevel", r, cp_level_r)
            @(posedge clk);
        end
        $display("test pump done");
        for (int v = 0; v < 13; v++) begin
            auto_vco <= 4'(v);
            @(posedge clk);
            @(negedge clk);
            `CHK("auto", v < 12 ? v : 11, vco_sel_r)
            @(posedge clk);
        end
        auto_vco <= 4'h3;
        fns_host_i.wr(8'h1e, 8'h85);
        fns_host_i.idle;
        @(negedge clk);
        `CHK("forced", 5, vco_sel_r)
        @(posedge clk);
        fns_host_i.wr(8'h1e, 8'h8d);
        fns_host_i.idle;
        @(negedge clk);
        // an out-of-range forced index keeps the last choice
        `CHK("badforce", 5, vco_sel_r)
        $display("test vco done");
        stop_test;
    end
endmodule // tb
`default_nettype wire
